// ### compare_match_pkg.sv
// constants, field layouts and mode codes for the compare match output unit
// Functional notes
// - compare holding value with selected timer
// - match drives pin high, low, toggle, latch
// - flag set on every compare match
// - software interrupt mode leaves pin alone
// - interrupt reaches processor only when enabled
// - zero control write clears output latch low
// - PWM output with ten bit duty
// - shared address: select bit picks register
// - unimplemented bits read as zero
// - toggle, init-low-set, init-high-clear codes
// - special event resets timer, starts conversion
// - all-zero mode disables and resets channel
// - holding value in low and high bytes
package compare_match_pkg;
   // ***************************************************************
   // register byte addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_CH4_CONTROL    = 8'h00;
   localparam logic [7:0] ADDR_CH4_LOW        = 8'h04;
   localparam logic [7:0] ADDR_CH4_HIGH       = 8'h08;
   localparam logic [7:0] ADDR_CH5_CONTROL    = 8'h0C;
   localparam logic [7:0] ADDR_CH5_LOW        = 8'h10;
   localparam logic [7:0] ADDR_CH5_HIGH       = 8'h14;
   localparam logic [7:0] ADDR_TIMER_SELECT   = 8'h18;
   localparam logic [7:0] ADDR_FLAGS_3        = 8'h1C;
   localparam logic [7:0] ADDR_ENABLES_3      = 8'h20;
   localparam logic [7:0] ADDR_SHARED         = 8'h24;
   localparam logic [7:0] ADDR_SHARED_SELECT  = 8'h28;
   // ***************************************************************
   // field positions and reset values
   // ***************************************************************
   localparam int         CTRL_WIDTH          = 6;
   localparam int         DUTY_LSB            = 4;
   localparam int         FLAG_CH4_BIT        = 1;
   localparam int         FLAG_CH5_BIT        = 2;
   localparam int         OD_CH4_BIT          = 3;
   localparam int         OD_CH5_BIT          = 4;
   localparam int         SEL_LOW_BIT         = 3;
   localparam int         SEL_HIGH_BIT        = 6;
   localparam int         SHARED_SEL_BIT      = 4;
   localparam logic [7:0] RESET_BYTE          = 8'h00;
   // ***************************************************************
   // mode field codes
   // ***************************************************************
   localparam logic [3:0] MODE_OFF            = 4'h0;
   localparam logic [3:0] MODE_TOGGLE         = 4'h2;
   localparam logic [3:0] MODE_INIT_LOW_SET   = 4'h8;
   localparam logic [3:0] MODE_INIT_HIGH_CLR  = 4'h9;
   localparam logic [3:0] MODE_SOFT_IRQ       = 4'hA;
   localparam logic [3:0] MODE_SPECIAL        = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP        = 2'h3;
endpackage

// ### channel_link_if.sv
// signals between the register side and one compare channel
interface channel_link_if;
   import compare_match_pkg::*;
   logic [3:0]  mode;          // channel mode field
   logic [1:0]  duty_low_bits; // two low duty bits
   logic [15:0] holding;       // channel holding value
   logic        ctrl_written;  // control register was just written
   logic [15:0] timer_count;   // selected compare timer
   logic [9:0]  pwm_count;     // selected pwm timer with low bits
   logic        period_match;  // pwm period end pulse
   logic        match;         // compare match pulse
   logic        special;       // special event pulse
   logic        drives_pin;    // channel owns the pin
   logic        level;         // output latch level
   logic [7:0]  duty_high;     // latched duty high byte
   modport unit (input mode, duty_low_bits, holding, ctrl_written, timer_count, pwm_count,
                 period_match, output match, special, drives_pin, level, duty_high);
   modport regs (output mode, duty_low_bits, holding, ctrl_written, timer_count, pwm_count,
                 period_match, input match, special, drives_pin, level, duty_high);
endinterface

// ### compare_channel.sv
// one compare and pwm channel: match detection and output latch
module compare_channel
   import compare_match_pkg::*;
(
   input  wire logic  mclk, // system clock
   input  wire logic  rst,  // synchronous reset
   channel_link_if.unit lnk // register side link
);
   logic       equal_prev;
   logic       equal_now;
   logic       compare_mode;
   logic       pwm_mode;
   logic       hit;
   logic [9:0] duty_latched;

   assign equal_now    = (lnk.holding == lnk.timer_count);
   assign compare_mode = (lnk.mode == MODE_TOGGLE) || (lnk.mode == MODE_INIT_LOW_SET)
                      || (lnk.mode == MODE_INIT_HIGH_CLR) || (lnk.mode == MODE_SOFT_IRQ)
                      || (lnk.mode == MODE_SPECIAL);
   assign pwm_mode     = (lnk.mode[3:2] == MODE_PWM_TOP);
   assign hit          = compare_mode && equal_now && !equal_prev;
   assign lnk.match    = hit;
   assign lnk.special  = hit && (lnk.mode == MODE_SPECIAL);
   // soft irq and special leave pin to port latch
   assign lnk.drives_pin = pwm_mode || (lnk.mode == MODE_TOGGLE)
                        || (lnk.mode == MODE_INIT_LOW_SET) || (lnk.mode == MODE_INIT_HIGH_CLR);
   assign lnk.duty_high  = duty_latched[9:2];

   // equality history, cleared while off and tracked in every other mode, so a change between active modes never fakes a match
   always_ff @(posedge mclk)
   begin
      if (rst || lnk.mode == MODE_OFF)
         equal_prev <= 1'b0;
      else
         equal_prev <= equal_now;
   end

   // output latch, separate from the port data latch
   always_ff @(posedge mclk)
   begin
      if (rst || lnk.mode == MODE_OFF)
         lnk.level <= 1'b0;
      else if (lnk.ctrl_written && lnk.mode == MODE_INIT_LOW_SET)
         lnk.level <= 1'b0;
      else if (lnk.ctrl_written && lnk.mode == MODE_INIT_HIGH_CLR)
         lnk.level <= 1'b1;
      else if (hit && lnk.mode == MODE_TOGGLE)
         lnk.level <= !lnk.level;
      else if (hit && lnk.mode == MODE_INIT_LOW_SET)
         lnk.level <= 1'b1;
      else if (hit && lnk.mode == MODE_INIT_HIGH_CLR)
         lnk.level <= 1'b0;
      // pwm set at period end unless duty is zero
      else if (pwm_mode && lnk.period_match)
         lnk.level <= ({lnk.holding[7:0], lnk.duty_low_bits} != 10'h000);
      else if (pwm_mode && lnk.pwm_count == duty_latched)
         lnk.level <= 1'b0;
   end

   // duty double buffer, loaded only at period end to avoid glitches
   always_ff @(posedge mclk)
   begin
      if (rst || lnk.mode == MODE_OFF)
         duty_latched <= 10'h000;
      else if (pwm_mode && lnk.period_match)
         duty_latched <= {lnk.holding[7:0], lnk.duty_low_bits};
   end
endmodule

// ### compare_match_output_unit.sv
// compare match output unit: register slave, timer selection and pin drive
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
module compare_match_output_unit
   import compare_match_pkg::*;
(
   input  wire logic        mclk,                 // system clock, 200 MHz
   input  wire logic        rst,                  // synchronous reset, active high
   input  wire logic        hsel,                 // slave select
   input  wire logic [31:0] haddr,                // byte address
   input  wire logic [1:0]  htrans,               // transfer type
   input  wire logic        hwrite,               // write when high
   input  wire logic [2:0]  hsize,                // transfer size, word only
   input  wire logic [31:0] hwdata,               // write data
   input  wire logic        hready,               // bus ready
   output      logic        hreadyout,            // slave ready
   output      logic [31:0] hrdata,               // read data
   output      logic        hresp,                // always okay
   input  wire logic [15:0] first_timer_count,    // first timer count
   input  wire logic [15:0] third_timer_count,    // third timer count
   input  wire logic [9:0]  pwm_timer2_count,     // second timer with low bits
   input  wire logic [9:0]  pwm_timer4_count,     // fourth timer with low bits
   input  wire logic        timer2_period_match,  // second timer period end
   input  wire logic        timer4_period_match,  // fourth timer period end
   input  wire logic [1:0]  port_latch,           // port data latch, ch4 bit 0
   input  wire logic [1:0]  port_g_direction,     // direction bits, 1 = input
   output      logic        channel4_pin_out,     // channel 4 pin level
   output      logic        channel4_pin_oe,      // channel 4 pin drive enable
   output      logic        channel5_pin_out,     // channel 5 pin level
   output      logic        channel5_pin_oe,      // channel 5 pin drive enable
   output      logic [1:0]  channel_irq_req,      // flag and enable per channel
   output      logic        first_timer_reset,    // special event reset pulse
   output      logic        third_timer_reset,    // special event reset pulse
   output      logic        adc_start,            // conversion start pulse
   output      logic        timer1_high_wr,       // legacy timer byte write pulse
   output      logic [7:0]  timer1_high_wdata     // legacy timer byte data
);
   import compare_match_pkg::*;

   // ********
   // register storage
   // ********
   logic [CTRL_WIDTH-1:0] channel_control_reg [2];
   logic [7:0]            holding_value_low   [2];
   logic [7:0]            holding_value_high  [2];
   logic [1:0]            ctrl_written;
   logic [7:0]            timer_select_control;
   logic [1:0]            channel_irq_flag;
   logic [1:0]            channel_irq_enable;
   logic [1:0]            open_drain_bits;
   logic                  shared_select;

   // ********
   // bus phase tracking
   // ********
   logic        addr_ok;
   logic        write_pend;
   logic        read_pend;
   logic [7:0]  data_addr;
   logic [31:0] next_rdata;
   logic        wr_ch4_ctrl;
   logic        wr_ch5_ctrl;

   // ********
   // channel links
   // ********
   logic        use_first_timer;
   logic [1:0]  chan_match;
   logic [1:0]  chan_special;
   logic [1:0]  chan_drives;
   logic [1:0]  chan_level;
   logic [7:0]  chan_duty_high [2];
   logic [1:0]  chan_pwm;

   channel_link_if link [2] ();

   // timer pairing: the first (and second) timer only when both select bits are clear
   assign use_first_timer = !timer_select_control[SEL_HIGH_BIT]
                         && !timer_select_control[SEL_LOW_BIT];

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : chan
         assign link[g].mode          = channel_control_reg[g][3:0];
         assign link[g].duty_low_bits = channel_control_reg[g][DUTY_LSB+1:DUTY_LSB];
         assign link[g].holding       = {holding_value_high[g], holding_value_low[g]};
         assign link[g].ctrl_written  = ctrl_written[g];
         assign link[g].timer_count   = use_first_timer ? first_timer_count
                                                        : third_timer_count;
         assign link[g].pwm_count     = use_first_timer ? pwm_timer2_count
                                                        : pwm_timer4_count;
         assign link[g].period_match  = use_first_timer ? timer2_period_match
                                                        : timer4_period_match;
         assign chan_match[g]         = link[g].match;
         assign chan_special[g]       = link[g].special;
         assign chan_drives[g]        = link[g].drives_pin;
         assign chan_level[g]         = link[g].level;
         assign chan_duty_high[g]     = link[g].duty_high;
         assign chan_pwm[g]           = (channel_control_reg[g][3:2] == MODE_PWM_TOP);

         compare_channel unit
         (
            .mclk (mclk),
            .rst  (rst),
            .lnk  (link[g])
         );
      end
   endgenerate

   // ********
   // bus slave
   // ********
   assign addr_ok   = hsel && htrans[1] && hready;
   // reads insert one wait state so a read right behind a write sees the new value
   assign hreadyout = !read_pend;
   assign hresp     = 1'b0;

   // data phase bookkeeping
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         write_pend <= 1'b0;
         read_pend  <= 1'b0;
         data_addr  <= RESET_BYTE;
      end
      else
      begin
         read_pend  <= addr_ok && !hwrite;
         write_pend <= addr_ok && hwrite;
         if (addr_ok)
            data_addr <= haddr[7:0];
      end
   end

   assign wr_ch4_ctrl = write_pend && (data_addr == ADDR_CH4_CONTROL);
   assign wr_ch5_ctrl = write_pend && (data_addr == ADDR_CH5_CONTROL);

   // read multiplexer
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (data_addr == ADDR_CH4_CONTROL)
         next_rdata[CTRL_WIDTH-1:0] = channel_control_reg[0];
      else if (data_addr == ADDR_CH4_LOW)
         next_rdata[7:0] = holding_value_low[0];
      else if (data_addr == ADDR_CH4_HIGH)
         next_rdata[7:0] = chan_pwm[0] ? chan_duty_high[0] : holding_value_high[0];
      else if (data_addr == ADDR_CH5_CONTROL)
         next_rdata[CTRL_WIDTH-1:0] = channel_control_reg[1];
      else if (data_addr == ADDR_CH5_LOW)
         next_rdata[7:0] = holding_value_low[1];
      else if (data_addr == ADDR_CH5_HIGH)
         next_rdata[7:0] = chan_pwm[1] ? chan_duty_high[1] : holding_value_high[1];
      else if (data_addr == ADDR_TIMER_SELECT)
         next_rdata[7:0] = timer_select_control;
      else if (data_addr == ADDR_FLAGS_3)
      begin
         next_rdata[FLAG_CH4_BIT] = channel_irq_flag[0];
         next_rdata[FLAG_CH5_BIT] = channel_irq_flag[1];
      end
      else if (data_addr == ADDR_ENABLES_3)
      begin
         next_rdata[FLAG_CH4_BIT] = channel_irq_enable[0];
         next_rdata[FLAG_CH5_BIT] = channel_irq_enable[1];
      end
      else if (data_addr == ADDR_SHARED && shared_select)
      begin
         next_rdata[OD_CH4_BIT] = open_drain_bits[0];
         next_rdata[OD_CH5_BIT] = open_drain_bits[1];
      end
      else if (data_addr == ADDR_SHARED)
         next_rdata[7:0] = first_timer_count[15:8];
      else if (data_addr == ADDR_SHARED_SELECT)
         next_rdata[SHARED_SEL_BIT] = shared_select;
   end

   // read data register, loaded in the wait state
   always_ff @(posedge mclk)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (read_pend)
         hrdata <= next_rdata;
   end

   // ********
   // channel registers
   // ********
   // control and holding bytes
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         channel_control_reg[0] <= RESET_BYTE[CTRL_WIDTH-1:0];
         channel_control_reg[1] <= RESET_BYTE[CTRL_WIDTH-1:0];
         holding_value_low[0]   <= RESET_BYTE;
         holding_value_low[1]   <= RESET_BYTE;
         holding_value_high[0]  <= RESET_BYTE;
         holding_value_high[1]  <= RESET_BYTE;
      end
      else if (write_pend)
      begin
         // zero then new mode, each one write
         if (data_addr == ADDR_CH4_CONTROL)
            channel_control_reg[0] <= hwdata[CTRL_WIDTH-1:0];
         else if (data_addr == ADDR_CH5_CONTROL)
            channel_control_reg[1] <= hwdata[CTRL_WIDTH-1:0];
         // bytes written one at a time
         else if (data_addr == ADDR_CH4_LOW)
            holding_value_low[0] <= hwdata[7:0];
         else if (data_addr == ADDR_CH5_LOW)
            holding_value_low[1] <= hwdata[7:0];
         // high byte is read-only while the channel is in pwm
         else if (data_addr == ADDR_CH4_HIGH && !chan_pwm[0])
            holding_value_high[0] <= hwdata[7:0];
         else if (data_addr == ADDR_CH5_HIGH && !chan_pwm[1])
            holding_value_high[1] <= hwdata[7:0];
      end
   end

   // control write marker, set on the same edge the register takes the new mode
   always_ff @(posedge mclk)
   begin
      if (rst)
         ctrl_written <= 2'b00;
      else
         ctrl_written <= {wr_ch5_ctrl, wr_ch4_ctrl};
   end

   // timer select and shared address select
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         timer_select_control <= RESET_BYTE;
         shared_select        <= 1'b0;
      end
      else if (write_pend && data_addr == ADDR_TIMER_SELECT)
         timer_select_control <= hwdata[7:0];
      else if (write_pend && data_addr == ADDR_SHARED_SELECT)
         shared_select <= hwdata[SHARED_SEL_BIT];
   end

   // open drain bits only with select set
   always_ff @(posedge mclk)
   begin
      if (rst)
         open_drain_bits <= 2'b00;
      else if (write_pend && data_addr == ADDR_SHARED && shared_select)
         open_drain_bits <= {hwdata[OD_CH5_BIT], hwdata[OD_CH4_BIT]};
   end

   // legacy timer byte write is forwarded to the timer, which owns the count
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         timer1_high_wr    <= 1'b0;
         timer1_high_wdata <= RESET_BYTE;
      end
      else
      begin
         timer1_high_wr <= write_pend && data_addr == ADDR_SHARED && !shared_select;
         if (write_pend && data_addr == ADDR_SHARED && !shared_select)
            timer1_high_wdata <= hwdata[7:0];
      end
   end

   // ********
   // flags and enables
   // ********
   // flag set on every compare match
   always_ff @(posedge mclk)
   begin
      if (rst)
         channel_irq_flag <= 2'b00;
      else if (write_pend && data_addr == ADDR_FLAGS_3)
         // a match in the clearing cycle still sets its flag
         channel_irq_flag <= {hwdata[FLAG_CH5_BIT], hwdata[FLAG_CH4_BIT]} | chan_match;
      else
         channel_irq_flag <= channel_irq_flag | chan_match;
   end

   // enable bits
   always_ff @(posedge mclk)
   begin
      if (rst)
         channel_irq_enable <= 2'b00;
      else if (write_pend && data_addr == ADDR_ENABLES_3)
         channel_irq_enable <= {hwdata[FLAG_CH5_BIT], hwdata[FLAG_CH4_BIT]};
   end

   assign channel_irq_req = channel_irq_flag & channel_irq_enable;

   // ********
   // special event and pin drive
   // ********
   // reset selected timer, start conversion
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         first_timer_reset <= 1'b0;
         third_timer_reset <= 1'b0;
         adc_start         <= 1'b0;
      end
      else
      begin
         first_timer_reset <= (|chan_special) && use_first_timer;
         third_timer_reset <= (|chan_special) && !use_first_timer;
         adc_start         <= |chan_special;
      end
   end

   // pin drivers; the output only drives when software made the pin an output
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         channel4_pin_out <= 1'b0;
         channel4_pin_oe  <= 1'b0;
         channel5_pin_out <= 1'b0;
         channel5_pin_oe  <= 1'b0;
      end
      else
      begin
         channel4_pin_out <= open_drain_bits[0] ? 1'b0
                           : (chan_drives[0] ? chan_level[0] : port_latch[0]);
         channel4_pin_oe  <= !port_g_direction[0]
                           && !(open_drain_bits[0]
                                && (chan_drives[0] ? chan_level[0] : port_latch[0]));
         channel5_pin_out <= open_drain_bits[1] ? 1'b0
                           : (chan_drives[1] ? chan_level[1] : port_latch[1]);
         channel5_pin_oe  <= !port_g_direction[1]
                           && !(open_drain_bits[1]
                                && (chan_drives[1] ? chan_level[1] : port_latch[1]));
      end
   end

   // size is not checked: every access is treated as a whole word
   logic unused_size;
   assign unused_size = ^hsize;
endmodule

// ### compare_timer_model.sv
// timer pair model feeding the compare unit
module compare_timer_model
(
   input  wire logic        mclk,        // system clock
   input  wire logic        run,         // count enable
   input  wire logic        clear,       // restart both counts
   input  wire logic        first_rst,   // special event reset, first timer
   input  wire logic        third_rst,   // special event reset, third timer
   output      logic [15:0] first_count, // first timer count
   output      logic [15:0] third_count  // third timer count
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // counters
   // ********
   // synchronous timer counting
   always_ff @(posedge mclk)
   begin
      first_count <= (clear || first_rst) ? 16'h0000 : first_count + 16'(run);
      third_count <= (clear || third_rst) ? 16'h0100 : third_count + 16'(run);
   end
endmodule

// ### compare_match_checker.sv
// port assertions for the compare match output unit
module compare_match_checker
   import compare_match_pkg::*;
(
   input wire logic        mclk,              // system clock
   input wire logic        rst,               // synchronous reset
   input wire logic        hsel,              // slave select
   input wire logic [31:0] haddr,             // byte address
   input wire logic [1:0]  htrans,            // transfer type
   input wire logic        hwrite,            // write when high
   input wire logic        hready,            // bus ready
   input wire logic        hreadyout,         // slave ready
   input wire logic [31:0] hrdata,            // read data
   input wire logic        first_timer_reset, // reset pulse
   input wire logic        third_timer_reset, // reset pulse
   input wire logic        adc_start,         // conversion pulse
   input wire logic        timer1_high_wr     // legacy byte write pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ********
   // bus and event checks
   // ********
   read_wait_a: assert property (
      hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_ready_a: assert property (
      hsel && htrans[1] && hready && hwrite |=> hreadyout) else $error("write stalled");
   zero_upper_a: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   adc_pulse_a: assert property (adc_start |=> !adc_start)
      else $error("conversion pulse too long");
   reset_with_adc_a: assert property (
      first_timer_reset || third_timer_reset |-> adc_start) else $error("reset without conversion");
   one_timer_a: assert property (
      adc_start |-> first_timer_reset != third_timer_reset) else $error("timer reset choice wrong");
   legacy_write_a: assert property (timer1_high_wr |->
      $past(hsel && htrans[1] && hready && hwrite && haddr[7:0] == ADDR_SHARED, 2))
      else $error("legacy write without bus write");
   legacy_pulse_a: assert property (timer1_high_wr |=> !timer1_high_wr)
      else $error("legacy write pulse too long");
endmodule
bind compare_match_output_unit compare_match_checker u_chk (.mclk, .rst, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hreadyout, .hrdata, .first_timer_reset, .third_timer_reset, .adc_start,
   .timer1_high_wr);

// ### tb_top.sv
// register level testbench for the compare match output unit
module tb_top;
   import compare_match_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst, hsel, hwrite, hreadyout, hresp, run, clear;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, channel_irq_req;
   logic [15:0] first_timer_count, third_timer_count;
   logic        channel4_pin_out, channel4_pin_oe, channel5_pin_out, channel5_pin_oe;
   logic        first_timer_reset, third_timer_reset, adc_start, timer1_high_wr;
   logic [7:0]  timer1_high_wdata;
   int          fail_count, checks_done, cyc, i, m;
   logic [3:0]  modes [4] = '{MODE_INIT_LOW_SET, MODE_INIT_HIGH_CLR, MODE_TOGGLE, MODE_SOFT_IRQ};
   logic        exp_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   compare_match_output_unit u_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
      .hsize(3'h2), .hready(hreadyout), .hreadyout, .hrdata, .hresp, .first_timer_count,
      .third_timer_count, .pwm_timer2_count(first_timer_count[9:0]),
      .pwm_timer4_count(third_timer_count[9:0]), .timer2_period_match(1'b0),
      .timer4_period_match(1'b0), .port_latch(2'b10), .port_g_direction(2'b00),
      .channel4_pin_out, .channel4_pin_oe, .channel5_pin_out, .channel5_pin_oe, .channel_irq_req,
      .first_timer_reset, .third_timer_reset, .adc_start, .timer1_high_wr, .timer1_high_wdata);
   compare_timer_model u_tmr (.mclk, .run, .clear, .first_rst(first_timer_reset),
      .third_rst(third_timer_reset), .first_count(first_timer_count), .third_count(third_timer_count));
   // clock and hang guard; a hang ends the run as a mismatch
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end
   // ********
   // tasks
   // ********
   // one single word transfer, address phase then data phase
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h000000, a}; hwrite <= w;
      @(posedge mclk); while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h000000, d};
      @(posedge mclk); while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask
   task chk(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ********
   // tests
   // ********
   initial
   begin
      rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
      run = 1'b0; clear = 1'b1; fail_count = 0; checks_done = 0; cyc = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0; clear <= 1'b0;
      @(posedge mclk);
      bus(0, ADDR_CH4_CONTROL, 8'h00); chk(32'h0, rd);
      bus(1, ADDR_CH4_CONTROL, 8'hFF); bus(0, ADDR_CH4_CONTROL, 8'h00); chk(32'h3F, rd);
      bus(1, 8'h3C, 8'h55); bus(0, 8'h3C, 8'h00); chk(32'h0, rd);
      bus(1, ADDR_CH4_CONTROL, 8'h00); bus(1, ADDR_CH4_HIGH, 8'hA5);
      bus(0, ADDR_CH4_HIGH, 8'h00); chk(32'hA5, rd);
      bus(1, ADDR_CH4_HIGH, 8'h00); bus(1, ADDR_CH4_LOW, 8'h40);
      bus(0, ADDR_CH4_LOW, 8'h00); chk(32'h40, rd);
      bus(1, ADDR_ENABLES_3, 8'h02);
      $display("test registers done");
      // each compare mode except special from a cleared channel, timer restarted at zero
      for (m = 0; m < 4; m++)
      begin
         clear <= 1'b1; run <= 1'b0;
         bus(1, ADDR_CH4_CONTROL, 8'h00); bus(1, ADDR_FLAGS_3, 8'h00);
         @(posedge mclk);
         chk(32'h0, channel4_pin_out);
         clear <= 1'b0;
         bus(1, ADDR_CH4_CONTROL, {4'h0, modes[m]}); run <= 1'b1;
         for (i = 0; i < 200 && first_timer_count < 16'h0048; i++) @(posedge mclk);
         chk(exp_pin[m], channel4_pin_out);
         chk(32'h1, channel4_pin_oe);
         chk(32'h1, channel_irq_req[0]);
         bus(0, ADDR_FLAGS_3, 8'h00); chk(32'h02, rd);
         bus(1, ADDR_FLAGS_3, 8'h00);
         for (i = 0; i < 200 && first_timer_count < 16'h0060; i++) @(posedge mclk);
         bus(0, ADDR_FLAGS_3, 8'h00); chk(32'h0, rd);
      end
      $display("test compare modes done");
      // special event on first timer then on third timer
      for (m = 0; m < 2; m++)
      begin
         clear <= 1'b1; run <= 1'b0;
         bus(1, ADDR_CH4_CONTROL, 8'h00); bus(1, ADDR_FLAGS_3, 8'h00);
         bus(1, ADDR_CH4_HIGH, 8'(m)); bus(1, ADDR_TIMER_SELECT, 8'(m * 8));
         clear <= 1'b0;
         bus(1, ADDR_CH4_CONTROL, {4'h0, MODE_SPECIAL}); run <= 1'b1;
         for (i = 0; i < 400 && !(first_timer_reset || third_timer_reset); i++) @(posedge mclk);
         chk(32'h1, (m == 0) ? first_timer_reset : third_timer_reset);
         bus(0, ADDR_FLAGS_3, 8'h00); chk(32'h02, rd);
         chk(32'h1, ((m == 0) ? first_timer_count : third_timer_count - 16'h0100) < 16'h0010);
      end
      $display("test special event done");
      run <= 1'b0;
      bus(1, ADDR_SHARED_SELECT, 8'h10); bus(1, ADDR_SHARED, 8'hFF);
      bus(0, ADDR_SHARED, 8'h00); chk(32'h18, rd);
      bus(1, ADDR_SHARED_SELECT, 8'h00); bus(1, ADDR_SHARED, 8'h5A);
      @(posedge mclk);
      chk(32'h5A, timer1_high_wdata);
      bus(0, ADDR_SHARED, 8'h00); chk({24'h000000, first_timer_count[15:8]}, rd);
      $display("test shared address done");
      complete_run();
   end
endmodule
